// [dmr_pkg.sv]
// constants for the mode register decode block
`default_nettype none
package dmr_pkg;
  // pin widths
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned WRC_W = 5;
  localparam int unsigned TRP_W = 5;
  localparam int unsigned DAL_W = 6;
  // bank codes that select a mode register
  localparam logic [2:0] BANK_MR0 = 3'h0;
  localparam logic [2:0] BANK_MR1 = 3'h1;
  // mode register zero field positions
  localparam int unsigned MR0_TM_BIT = 7;
  localparam int unsigned MR0_DLL_RESET_REQUEST_BIT = 8;
  localparam int unsigned MR0_WR_LSB = 9;
  localparam int unsigned MR0_WR_MSB = 11;
  localparam int unsigned MR0_PPD_BIT = 12;
  // mode register one field positions
  localparam int unsigned MR1_DLLDIS_BIT = 0;
  localparam int unsigned MR1_DRV_LO_BIT = 1;
  localparam int unsigned MR1_ODT_LO_BIT = 2;
  localparam int unsigned MR1_AL_LSB = 3;
  localparam int unsigned MR1_AL_MSB = 4;
  localparam int unsigned MR1_DRV_HI_BIT = 5;
  localparam int unsigned MR1_ODT_MID_BIT = 6;
  localparam int unsigned MR1_WLVL_BIT = 7;
  localparam int unsigned MR1_ODT_HI_BIT = 9;
  localparam int unsigned MR1_TERMINATION_STROBE_ENABLE_BIT = 11;
  localparam int unsigned MR1_QOFF_BIT = 12;
  // reset values of the stored registers
  localparam logic [14:0] MR_RESET = 15'h0000;
  // write recovery codes and the cycle counts they select
  localparam logic [2:0] WR_CODE_RSVD = 3'h0;
  localparam logic [4:0] WR_CYC_RSVD = 5'h00;
  localparam logic [4:0] WR_CYC_5 = 5'h05;
  localparam logic [4:0] WR_CYC_6 = 5'h06;
  localparam logic [4:0] WR_CYC_7 = 5'h07;
  localparam logic [4:0] WR_CYC_8 = 5'h08;
  localparam logic [4:0] WR_CYC_10 = 5'h0A;
  localparam logic [4:0] WR_CYC_12 = 5'h0C;
  localparam logic [4:0] WR_CYC_14 = 5'h0E;
  // command clock period and the system clock period, in ns
  localparam int unsigned CK_PERIOD_NS = 400;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CK_CYCLES = CK_PERIOD_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// [dmr_decode.sv]
// mode register set decode for mode registers zero and one
`default_nettype none
module dmr_decode (
  input wire logic clock,
  input wire logic reset_n,
  // command pins, in the command clock's domain
  input wire logic cmd_clk,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [dmr_pkg::BANK_W-1:0] bank_addr,
  input wire logic [dmr_pkg::ADDR_W-1:0] addr,
  // device core state, same clock
  input wire logic powerdown_active,
  input wire logic banks_open,
  input wire logic [dmr_pkg::TRP_W-1:0] row_precharge_cycles,
  // decoded settings
  output logic [dmr_pkg::ADDR_W-1:0] mode_reg_zero,
  output logic [dmr_pkg::ADDR_W-1:0] mode_reg_one,
  output logic normal_mode,
  output logic dll_reset_request,
  output logic [dmr_pkg::WRC_W-1:0] write_recovery_cycles,
  output logic write_recovery_reserved,
  output logic [dmr_pkg::DAL_W-1:0] autoprecharge_write_delay,
  output logic precharge_powerdown_dll_ctrl,
  output logic dll_freeze,
  output logic output_disable,
  output logic termination_strobe_enable,
  output logic write_level_enable,
  output logic dll_disable,
  output logic [2:0] nominal_termination_select,
  output logic [1:0] driver_strength_select,
  output logic [1:0] additive_latency
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] ctl_s1_q; // first stage, read only by the second
  logic [3:0] ctl_s2_q; // second stage of cs, ras, cas, we
  logic [3:0] ctl_s2_d;
  logic [2:0] ba_s1_q; // first stage bank address
  logic [2:0] ba_s2_q;
  logic [2:0] ba_s2_d;
  logic [14:0] ad_s1_q; // first stage address
  logic [14:0] ad_s2_q;
  logic [14:0] ad_s2_d;
  logic ck_s1_q; // first stage command clock
  logic ck_s2_q;
  logic ck_s3_q; // edge detect history, reads stage two only
  logic ck_s2_d;
  logic ck_s3_d;
  logic ck_rise; // command clock rising edge seen

  // two flops per pin, three on the command clock; the pins settle long before the slow clock edge
  always_comb begin
    ctl_s2_d = ctl_s1_q;
    ba_s2_d = ba_s1_q;
    ad_s2_d = ad_s1_q;
    ck_s2_d = ck_s1_q;
    ck_s3_d = ck_s2_q;
  end

  // register the synchroniser stages
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctl_s1_q <= 4'hF;
      ctl_s2_q <= 4'hF;
      ba_s1_q <= 3'h0;
      ba_s2_q <= 3'h0;
      ad_s1_q <= 15'h0000;
      ad_s2_q <= 15'h0000;
      ck_s1_q <= 1'h0;
      ck_s2_q <= 1'h0;
      ck_s3_q <= 1'h0;
    end else begin
      ctl_s1_q <= {cs_n, ras_n, cas_n, we_n};
      ctl_s2_q <= ctl_s2_d;
      ba_s1_q <= bank_addr;
      ba_s2_q <= ba_s2_d;
      ad_s1_q <= addr;
      ad_s2_q <= ad_s2_d;
      ck_s1_q <= cmd_clk;
      ck_s2_q <= ck_s2_d;
      ck_s3_q <= ck_s3_d;
    end
  end

  assign ck_rise = ck_s2_q && !ck_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  logic mrs_cmd; // all four strobes low at a command clock rising edge
  logic mr0_wr;
  logic mr1_wr;

  always_comb begin
    mrs_cmd = ck_rise && (ctl_s2_q == 4'h0);
    mr0_wr = mrs_cmd && (ba_s2_q == dmr_pkg::BANK_MR0);
    mr1_wr = mrs_cmd && (ba_s2_q == dmr_pkg::BANK_MR1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // write recovery code to cycles
  function automatic logic [4:0] wr_decode(input logic [2:0] code);
    logic [4:0] cyc;
    cyc = dmr_pkg::WR_CYC_RSVD;
    unique case (code)
      3'h0: cyc = dmr_pkg::WR_CYC_RSVD;
      3'h1: cyc = dmr_pkg::WR_CYC_5;
      3'h2: cyc = dmr_pkg::WR_CYC_6;
      3'h3: cyc = dmr_pkg::WR_CYC_7;
      3'h4: cyc = dmr_pkg::WR_CYC_8;
      3'h5: cyc = dmr_pkg::WR_CYC_10;
      3'h6: cyc = dmr_pkg::WR_CYC_12;
      3'h7: cyc = dmr_pkg::WR_CYC_14;
    endcase
    return cyc;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode register state
  logic [14:0] mr0_q; // stored register zero, reset bit self-clears
  logic [14:0] mr0_d;
  logic [14:0] mr1_q;
  logic [14:0] mr1_d;
  logic [4:0] wrc_q; // decoded write recovery cycles
  logic [4:0] wrc_d;
  logic wr_rsvd_q;
  logic wr_rsvd_d;
  logic [5:0] dal_q;
  logic [5:0] dal_d;
  logic freeze_q;
  logic freeze_d;
  logic [2:0] wr_code;

  // next values of all stored settings
  always_comb begin
    mr0_d = mr0_q;
    mr1_d = mr1_q;
    // reset request lasts one cycle then clears
    mr0_d[dmr_pkg::MR0_DLL_RESET_REQUEST_BIT] = 1'b0;
    if (mr0_wr) begin
      // whole word kept; high address bits stored as driven
      mr0_d = ad_s2_q;
    end
    if (mr1_wr) begin
      mr1_d = ad_s2_q;
    end
    wr_code = mr0_d[dmr_pkg::MR0_WR_MSB:dmr_pkg::MR0_WR_LSB];
    wrc_d = wr_decode(wr_code);
    wr_rsvd_d = (wr_code == dmr_pkg::WR_CODE_RSVD);
    dal_d = {1'b0, wrc_q} + {1'b0, row_precharge_cycles};
    // slow exit freezes in precharge powerdown
    // open banks mean active powerdown, dll stays on
    freeze_d = powerdown_active && !banks_open && !mr0_q[dmr_pkg::MR0_PPD_BIT];
  end

  // register stored settings
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mr0_q <= dmr_pkg::MR_RESET;
      mr1_q <= dmr_pkg::MR_RESET;
      wrc_q <= dmr_pkg::WR_CYC_RSVD;
      wr_rsvd_q <= 1'b1;
      dal_q <= 6'h00;
      freeze_q <= 1'b0;
    end else begin
      mr0_q <= mr0_d;
      mr1_q <= mr1_d;
      wrc_q <= wrc_d;
      wr_rsvd_q <= wr_rsvd_d;
      dal_q <= dal_d;
      freeze_q <= freeze_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign mode_reg_zero = mr0_q;
  assign mode_reg_one = mr1_q;
  // normal mode when test bit clear
  assign normal_mode = !mr0_q[dmr_pkg::MR0_TM_BIT];
  assign dll_reset_request = mr0_q[dmr_pkg::MR0_DLL_RESET_REQUEST_BIT];
  assign write_recovery_cycles = wrc_q;
  assign write_recovery_reserved = wr_rsvd_q;
  assign autoprecharge_write_delay = dal_q;
  assign precharge_powerdown_dll_ctrl = mr0_q[dmr_pkg::MR0_PPD_BIT];
  assign dll_freeze = freeze_q;
  assign output_disable = mr1_q[dmr_pkg::MR1_QOFF_BIT];
  assign termination_strobe_enable = mr1_q[dmr_pkg::MR1_TERMINATION_STROBE_ENABLE_BIT];
  assign write_level_enable = mr1_q[dmr_pkg::MR1_WLVL_BIT];
  assign dll_disable = mr1_q[dmr_pkg::MR1_DLLDIS_BIT];
  assign nominal_termination_select = {mr1_q[dmr_pkg::MR1_ODT_HI_BIT],
    mr1_q[dmr_pkg::MR1_ODT_MID_BIT], mr1_q[dmr_pkg::MR1_ODT_LO_BIT]};
  assign driver_strength_select = {mr1_q[dmr_pkg::MR1_DRV_HI_BIT],
    mr1_q[dmr_pkg::MR1_DRV_LO_BIT]};
  assign additive_latency = mr1_q[dmr_pkg::MR1_AL_MSB:dmr_pkg::MR1_AL_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_mr0_load_word: assert property (mr0_wr |=> mode_reg_zero == $past(ad_s2_q))
    else $error("register zero not loaded");

  a_mr1_load_word: assert property (mr1_wr |=> mode_reg_one == $past(ad_s2_q))
    else $error("register one not loaded");

  // other banks leave register one alone
  a_mr1_hold_other: assert property (!mr1_wr |=> $stable(mode_reg_one))
    else $error("register one changed without its command");

  a_dll_self_clear: assert property ($rose(dll_reset_request) |=> !dll_reset_request)
    else $error("dll reset request did not clear itself");

  // a write with bit 8 raises the request
  a_dll_req_set: assert property (
    mr0_wr && ad_s2_q[dmr_pkg::MR0_DLL_RESET_REQUEST_BIT] |=> dll_reset_request)
    else $error("dll reset request not raised");

  // code 101 gives ten cycles two edges later
  a_wr_code_ten: assert property (
    mr0_wr && ad_s2_q[11:9] == 3'h5 ##1 !mr0_wr |=> write_recovery_cycles == 5'h0A)
    else $error("write recovery decode wrong");

  // delay equals recovery plus precharge
  // the first edge after release still shows the delay held in reset
  a_dal_sum: assert property ($past(reset_n) |->
    autoprecharge_write_delay == {1'b0, $past(write_recovery_cycles)}
      + {1'b0, $past(row_precharge_cycles)})
    else $error("autoprecharge delay sum wrong");

  a_slow_exit_frz: assert property (
    powerdown_active && !banks_open && !precharge_powerdown_dll_ctrl |=> dll_freeze)
    else $error("dll not frozen in slow exit");

  a_active_pd_on: assert property (powerdown_active && banks_open |=> !dll_freeze)
    else $error("dll frozen in active powerdown");

  a_fast_exit_run: assert property (precharge_powerdown_dll_ctrl |=> !dll_freeze)
    else $error("dll frozen in fast exit");

  // a write with the test bit clear selects normal mode
  a_normal_mode: assert property (
    mr0_wr && !ad_s2_q[dmr_pkg::MR0_TM_BIT] |=> normal_mode)
    else $error("normal mode not selected");

  a_odt_split: assert property (
    mr1_wr |=> nominal_termination_select == {$past(ad_s2_q[9]), $past(ad_s2_q[6]),
      $past(ad_s2_q[2])})
    else $error("termination field misplaced");

  // main scenarios
  c_mr0_write: cover property (mr0_wr);
  c_mr1_write: cover property (mr1_wr);
  c_dll_reset: cover property ($rose(dll_reset_request));
  c_dll_freeze: cover property ($rose(dll_freeze));

endmodule
`default_nettype wire

// [dmr_ctrl_model.sv]
// controller model that issues mode register set commands
`default_nettype none
module dmr_ctrl_model (
  output var logic cmd_clk,
  output var logic cs_n,
  output var logic ras_n,
  output var logic cas_n,
  output var logic we_n,
  output var logic [2:0] bank_addr,
  output var logic [14:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: deselected, command clock parked low between frames
  initial begin
    cmd_clk = 1'b0;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    bank_addr = 3'h7;
    addr = 15'h0000;
  end
  ////////////////////////////////////////////////////////////
  // one 400 ns command frame; pins set 13 ns off the system clock edge
  // is_mrs low sends the command with we_n high, which the block must ignore
  task automatic send(input logic [2:0] bank, input logic [14:0] a, input logic is_mrs);
    logic [14:0] w;
    w = a;
    w[14:13] = 2'h0;
    if (bank == 3'h1) begin
      w[10] = 1'b0;
      w[8] = 1'b0;
    end
    #13;
    cs_n = 1'b0;
    {ras_n, cas_n} = 2'h0;
    we_n = ~is_mrs;
    bank_addr = bank;
    addr = w;
    #100 cmd_clk = 1'b1;
    #200 cmd_clk = 1'b0;
    // let go 12 ns before the next system edge, never on it, to avoid a sampling race
    // inverted values so stale pins never look valid
    #75 cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    bank_addr = ~bank;
    addr = ~w;
  endtask
endmodule
`default_nettype wire

// [test_ddr3_mode_register_decode.sv]
// self-checking bench for the mode register decode block
`default_nettype none
module test_ddr3_mode_register_decode;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 2000; // cycle ceiling; the run needs about 220
  localparam int DLL_LOCK_CYC = 16; // lock wait stand-in, value arbitrary
  logic clock, reset_n, cmd_clk, cs_n, ras_n, cas_n, we_n, powerdown_active, banks_open;
  logic [2:0] bank_addr, nominal_termination_select;
  logic [14:0] addr, mode_reg_zero, mode_reg_one, w, e;
  logic [4:0] row_precharge_cycles, write_recovery_cycles;
  logic [5:0] autoprecharge_write_delay;
  logic normal_mode, dll_reset_request, write_recovery_reserved, precharge_powerdown_dll_ctrl;
  logic dll_freeze, output_disable, termination_strobe_enable, write_level_enable, dll_disable;
  logic [1:0] driver_strength_select, additive_latency;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int pulses = 0;
  int k; // minimum write recovery in command clock cycles
  int wr_ns [2] = '{3600, 4400}; // write_recovery_time stand-ins in ns, chosen to need 9 and 11 cycles
  logic [4:0] wr_tab [8] = '{dmr_pkg::WR_CYC_RSVD, dmr_pkg::WR_CYC_5, dmr_pkg::WR_CYC_6,
    dmr_pkg::WR_CYC_7, dmr_pkg::WR_CYC_8, dmr_pkg::WR_CYC_10, dmr_pkg::WR_CYC_12,
    dmr_pkg::WR_CYC_14};
  logic [14:0] mr1_pat [2] = '{15'h1AFF, 15'h0A5A};
  dmr_decode u_dut (.clock, .reset_n, .cmd_clk, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr,
    .addr, .powerdown_active, .banks_open, .row_precharge_cycles, .mode_reg_zero,
    .mode_reg_one, .normal_mode, .dll_reset_request, .write_recovery_cycles,
    .write_recovery_reserved, .autoprecharge_write_delay, .precharge_powerdown_dll_ctrl,
    .dll_freeze, .output_disable, .termination_strobe_enable, .write_level_enable,
    .dll_disable, .nominal_termination_select, .driver_strength_select, .additive_latency);
  dmr_ctrl_model u_ctrl (.cmd_clk, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr, .addr);
  ////////////////////////////////////////////////////////////
  // 20 MHz system clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // counts reset pulses; a pulse lasts one cycle so only an edge sampler sees it
  always @(posedge clock) begin
    if (dll_reset_request === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // smallest code covering the minimum
  // codes for 9 and 11 do not exist, so the next larger one is taken
  function automatic logic [2:0] wr_pick(input int min_cyc);
    wr_pick = 3'h7;
    for (int j = 7; j > 0; j--) begin
      if (int'(wr_tab[j]) >= min_cyc) begin
        wr_pick = 3'(j);
      end
    end
  endfunction
  // one command, then wait out the decode pipeline
  task automatic mrs(input logic [2:0] bank, input logic [14:0] a, input logic ok);
    u_ctrl.send(bank, a, ok);
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic freeze(input logic pd, input logic open_b, input logic exp);
    @(posedge clock);
    powerdown_active <= pd;
    banks_open <= open_b;
    repeat (3) @(posedge clock);
    #1;
    chk("dll_freeze", 15'(exp), 15'(dll_freeze));
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    powerdown_active = 1'b0;
    banks_open = 1'b0;
    row_precharge_cycles = 5'h0B;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1;
    chk("mr0_reset", dmr_pkg::MR_RESET, mode_reg_zero);
    chk("normal_reset", 15'h1, 15'(normal_mode));
    chk("wr_rsvd_reset", 15'h1, 15'(write_recovery_reserved));
    $display("test reset done");
    // every write recovery code, precharge time varied alongside
    for (int c = 0; c < 8; c++) begin
      @(posedge clock);
      row_precharge_cycles <= 5'(c + 3);
      w = {2'h0, c[0], c[2:0], 1'b0, (c == 6), 7'h2A};
      mrs(dmr_pkg::BANK_MR0, w, 1'b1);
      chk("mr0", w, mode_reg_zero);
      chk("normal", 15'(c != 6), 15'(normal_mode));
      chk("wr_cycles", 15'(wr_tab[c]), 15'(write_recovery_cycles));
      chk("wr_rsvd", 15'(c == 0), 15'(write_recovery_reserved));
      e = 15'(wr_tab[c]) + 15'(c + 3);
      chk("dal", e, 15'(autoprecharge_write_delay));
      chk("ppd", 15'(c[0]), 15'(precharge_powerdown_dll_ctrl));
    end
    chk("no_pulse", 15'h0, 15'(pulses));
    // minimums of 9 and 11 cycles must be programmed as 10 and 12
    foreach (wr_ns[i]) begin
      k = (wr_ns[i] + dmr_pkg::CK_PERIOD_NS - 1) / dmr_pkg::CK_PERIOD_NS;
      mrs(dmr_pkg::BANK_MR0, {2'h0, 1'b0, wr_pick(k), 9'h000}, 1'b1);
      chk("wr_rounded", 15'(wr_tab[3'(i) + 3'h5]), 15'(write_recovery_cycles));
    end
    $display("test write recovery done");
    mrs(dmr_pkg::BANK_MR1, 15'h0000, 1'b1);
    mrs(dmr_pkg::BANK_MR0, 15'h0300, 1'b1);
    chk("dll_pulses", 15'h1, 15'(pulses));
    chk("mr0_selfclr", 15'h0200, mode_reg_zero);
    chk("dll_req_low", 15'h0, 15'(dll_reset_request));
    repeat (DLL_LOCK_CYC) @(posedge clock);
    $display("test dll reset done");
    foreach (mr1_pat[i]) begin
      w = mr1_pat[i];
      mrs(dmr_pkg::BANK_MR1, w, 1'b1);
      chk("mr1", w, mode_reg_one);
      chk("mr0_kept", 15'h0200, mode_reg_zero);
      e = 15'({output_disable, termination_strobe_enable, write_level_enable, dll_disable});
      chk("mr1_bits", 15'({w[12], w[11], w[7], w[0]}), e);
      e = 15'({nominal_termination_select, driver_strength_select, additive_latency});
      chk("mr1_split", 15'({w[9], w[6], w[2], w[5], w[1], w[4], w[3]}), e);
    end
    $display("test mode register one done");
    mrs(3'h2, 15'h7FFF, 1'b1);
    mrs(dmr_pkg::BANK_MR0, 15'h7FFF, 1'b0);
    chk("mr0_refused", 15'h0200, mode_reg_zero);
    chk("mr1_refused", 15'h0A5A, mode_reg_one);
    $display("test ignored commands done");
    freeze(1'b1, 1'b0, 1'b1);
    freeze(1'b1, 1'b1, 1'b0);
    freeze(1'b0, 1'b0, 1'b0);
    mrs(dmr_pkg::BANK_MR0, 15'h1200, 1'b1);
    freeze(1'b1, 1'b0, 1'b0);
    $display("test power-down done");
    finish_test();
  end
endmodule
`default_nettype wire
